// >>> dual_integrator_sequencer.sv
// Integrate and measure sequencer with ready flag and result buffering
`timescale 1ns/1ps
module dual_integrator_sequencer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Conversion control
	input wire logic integrate_side_select,
	input wire logic quarter_rate_divider,
	input wire logic high_speed_version,
	// Readout
	input wire logic data_shift_clock,
	output logic result_ready_n,
	output logic [sequencer_pkg::WORD_W-1:0] result_word,
	// Front-end steering
	output logic [2:0] seq_state,
	output logic integrate_a,
	output logic integrate_b,
	output logic inputs_grounded
);
	import sequencer_pkg::*;

	typedef struct packed {
		logic started;
		logic [DIV_W-1:0] div;
		logic integrate_side_select_s;
		seq_state_t state;
		logic busy;
		logic side;
		logic second;
		logic pushed;
		logic [CNT_W-1:0] cnt;
		logic [SEQ_W-1:0] seq;
		logic shown;
		logic armed;
		logic [WORD_W-1:0] word;
		logic ready_n;
		logic integ_a;
		logic integ_b;
		logic grounded;
	} seq_regs_t;

	seq_regs_t r_reg;
	seq_regs_t r_next;
	logic tick;
	logic go;
	logic go_side;
	logic [CNT_W-1:0] cycle_last;
	logic [CNT_W-1:0] ready_last;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [WORD_W-1:0] fifo_out_data;

	// Results wait here so a slow reader stalls the measure engine, not loses words
	result_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({r_reg.side, r_reg.seq}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Last count of a measure cycle and of the ready point
	assign cycle_last = (high_speed_version ? MEASURE_CYCLE_FAST : MEASURE_CYCLE_LOW) - CNT_STEP;
	// Pipeline stages are taken off so the flag itself lands on the delay
	assign ready_last = SEAMLESS_READY_DELAY - READY_PIPE;

	// Next-state logic for the whole block
	always_comb begin
		r_next = r_reg;
		go = 1'b0;
		go_side = SIDE_A;
		// Internal clock edge every cycle, or every fourth with the divider on
		tick = r_reg.div == DIV_TICK;
		r_next.div = quarter_rate_divider ? r_reg.div + DIV_STEP : DIV_TICK;
		// Result offered once per measure cycle; held while the buffer is full
		fifo_in_valid = r_reg.busy && r_reg.cnt == ready_last && !r_reg.pushed;
		fifo_out_ready = tick && !r_reg.shown;
		if (fifo_in_valid && fifo_in_ready) begin
			r_next.pushed = 1'b1;
			r_next.seq = r_reg.seq + SEQ_STEP;
		end
		if (tick) begin
			r_next.integrate_side_select_s = integrate_side_select;
			// Measure engine: busy spans the whole cycle, a full buffer freezes it
			if (r_reg.busy && !(r_reg.cnt == ready_last && !r_next.pushed)) begin
				if (r_reg.cnt == cycle_last) begin
					r_next.cnt = '0;
					r_next.pushed = 1'b0;
					if (r_reg.second) begin
						r_next.side = ~r_reg.side;
						r_next.second = 1'b0;
					end else begin
						r_next.busy = 1'b0;
					end
				end else begin
					r_next.cnt = r_reg.cnt + CNT_STEP;
				end
			end
			if (!r_reg.started) begin
				// Select level caught at the first internal edge after reset
				r_next.started = 1'b1;
				r_next.state = integrate_side_select ? ST1_FINISH_A : ST8_FINISH_B;
			end else begin
				// Level-driven walk; each arm mirrors its partner with select inverted
				unique case (r_reg.state)
					ST1_FINISH_A: begin
						if (!r_reg.busy) begin
							r_next.state = ST2_PREP_A;
						end
					end
					ST2_PREP_A: begin
						r_next.state = ST3_INT_A;
					end
					ST3_INT_A: begin
						if (!r_reg.integrate_side_select_s) begin
							r_next.state = ST4_INT_B_MEAS_A;
							go = 1'b1;
							go_side = SIDE_A;
						end
					end
					ST4_INT_B_MEAS_A: begin
						if (r_reg.integrate_side_select_s) begin
							go_side = SIDE_B;
							if (r_reg.busy) begin
								// Integration outran the measure cycle: halt
								r_next.state = ST1_FINISH_A;
								r_next.second = r_next.busy;
								go = !r_next.busy;
							end else begin
								r_next.state = ST5_INT_A_MEAS_B;
								go = 1'b1;
							end
						end
					end
					ST5_INT_A_MEAS_B: begin
						if (!r_reg.integrate_side_select_s) begin
							go_side = SIDE_A;
							if (r_reg.busy) begin
								r_next.state = ST8_FINISH_B;
								r_next.second = r_next.busy;
								go = !r_next.busy;
							end else begin
								r_next.state = ST4_INT_B_MEAS_A;
								go = 1'b1;
							end
						end
					end
					ST6_INT_B: begin
						if (r_reg.integrate_side_select_s) begin
							r_next.state = ST5_INT_A_MEAS_B;
							go = 1'b1;
							go_side = SIDE_B;
						end
					end
					ST7_PREP_B: begin
						r_next.state = ST6_INT_B;
					end
					ST8_FINISH_B: begin
						if (!r_reg.busy) begin
							r_next.state = ST7_PREP_B;
						end
					end
				endcase
			end
			if (go) begin
				r_next.busy = 1'b1;
				r_next.cnt = '0;
				r_next.side = go_side;
				r_next.pushed = 1'b0;
				r_next.second = 1'b0;
			end
		end
		// Ready flag: load on an internal edge, release after shift clock high then low
		if (!r_reg.shown) begin
			r_next.armed = 1'b0;
			if (fifo_out_ready && fifo_out_valid) begin
				r_next.shown = 1'b1;
				r_next.word = fifo_out_data;
				r_next.ready_n = 1'b0;
			end
		end else if (r_reg.armed && !data_shift_clock) begin
			r_next.shown = 1'b0;
			r_next.armed = 1'b0;
			r_next.ready_n = 1'b1;
		end else if (data_shift_clock) begin
			r_next.armed = 1'b1;
		end
		// Front-end controls follow the next state so outputs stay registered
		r_next.integ_a = integrates_a(r_next.state);
		r_next.integ_b = integrates_b(r_next.state);
		r_next.grounded = is_halted(r_next.state);
	end

	// Single state register; reset parks the machine halted with ready released
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= '0;
			r_reg.state <= ST8_FINISH_B;
			r_reg.ready_n <= 1'b1;
			r_reg.grounded <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign result_ready_n = r_reg.ready_n;
	assign result_word = r_reg.word;
	assign seq_state = r_reg.state;
	assign integrate_a = r_reg.integ_a;
	assign integrate_b = r_reg.integ_b;
	assign inputs_grounded = r_reg.grounded;

	// Checks; helper remembers which side integrated last
	localparam int RDY_LO = int'(SEAMLESS_READY_DELAY) - 2;
	localparam int RDY_HI = int'(SEAMLESS_READY_DELAY) + 2;
	localparam int OFFER_TO_FLAG = 2;
	logic [1:0] last_int_reg;
	logic sel_d_reg;
	logic [CNT_W-1:0] sel_age_reg;

	// Clock periods since select last changed, saturating
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sel_d_reg <= 1'b0;
			sel_age_reg <= '0;
		end else begin
			sel_d_reg <= integrate_side_select;
			if (integrate_side_select != sel_d_reg) begin
				sel_age_reg <= CNT_STEP;
			end else if (sel_age_reg != '1) begin
				sel_age_reg <= sel_age_reg + CNT_STEP;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_int_reg <= 2'h0;
		end else if (integrate_a || integrate_b) begin
			last_int_reg <= {1'b1, integrate_b};
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence shift_pulse_s;
		!result_ready_n && data_shift_clock ##1 !data_shift_clock;
	endsequence

	sequence toggle_while_busy_s;
		r_reg.started && tick && r_reg.busy && ((r_reg.state == ST4_INT_B_MEAS_A && r_reg.integrate_side_select_s)
		|| (r_reg.state == ST5_INT_A_MEAS_B && !r_reg.integrate_side_select_s));
	endsequence

	grounded_halted_a: assert property (inputs_grounded == (seq_state == ST1_FINISH_A
		|| seq_state == ST2_PREP_A || seq_state == ST7_PREP_B || seq_state == ST8_FINISH_B))
		else $error("grounding does not match halted state");
	side_alternate_a: assert property ($rose(integrate_a) && last_int_reg[1] |-> last_int_reg[0])
		else $error("side A integrated twice in a row");
	side_alternate_b_a: assert property ($rose(integrate_b) && last_int_reg[1] |-> !last_int_reg[0])
		else $error("side B integrated twice in a row");
	ready_release_a: assert property (shift_pulse_s |=> result_ready_n)
		else $error("ready not released after shift clock pulse");
	ready_hold_a: assert property (!result_ready_n && !data_shift_clock
		&& !$past(data_shift_clock) |=> !result_ready_n)
		else $error("ready released without shift clock");
	ready_delay_a: assert property ($rose(fifo_in_valid) && !quarter_rate_divider
		&& (r_reg.state == ST4_INT_B_MEAS_A || r_reg.state == ST5_INT_A_MEAS_B)
		|-> int'(sel_age_reg) + OFFER_TO_FLAG >= RDY_LO
		&& int'(sel_age_reg) + OFFER_TO_FLAG <= RDY_HI)
		else $error("result not offered at the ready delay");
	halt_on_busy_a: assert property (toggle_while_busy_s |=> r_reg.busy
		&& r_reg.state == (($past(r_reg.state) == ST4_INT_B_MEAS_A) ? ST1_FINISH_A : ST8_FINISH_B))
		else $error("toggle while busy did not halt");
	powerup_state_a: assert property (!r_reg.started && tick |=> r_reg.state ==
		($past(integrate_side_select) ? ST1_FINISH_A : ST8_FINISH_B))
		else $error("wrong power-up state");
	quarter_tick_a: assert property (quarter_rate_divider && tick
		&& $past(quarter_rate_divider) |=> !tick[*3])
		else $error("internal clock not divided by four");
	second_side_a: assert property (tick && r_reg.busy && r_reg.second && r_reg.pushed
		&& r_reg.cnt == cycle_last |=> r_reg.busy && r_reg.side != $past(r_reg.side))
		else $error("second side not measured");
endmodule

// >>> host_model.sv
// Host model: polls the ready flag and pulls words with the data shift clock
`timescale 1ns/1ps
module host_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Bench control
	input wire logic read_en,
	// Readout
	input wire logic result_ready_n,
	input wire logic [sequencer_pkg::WORD_W-1:0] result_word,
	output logic data_shift_clock,
	// Collected words
	output logic [sequencer_pkg::WORD_W-1:0] got_word,
	output int got_count
);
	import sequencer_pkg::*;
	logic [1:0] phase;

	// Single converter, no chain input to drive; it would sit low
	// Words carry no analog value, so nothing is dropped after reset
	// No timing from select: the flag is polled, so its phase jitter is harmless
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase <= 2'h0;
			data_shift_clock <= 1'b0;
			got_word <= '0;
			got_count <= 0;
		end else case (phase)
			2'h0: if (read_en && result_ready_n === 1'b0) begin
				got_word <= result_word;
				got_count <= got_count + 1;
				data_shift_clock <= 1'b1;
				phase <= 2'h1;
			end
			2'h1: begin
				data_shift_clock <= 1'b0;
				phase <= 2'h2;
			end
			// Wait for release so one word is never taken twice
			default: if (result_ready_n === 1'b1) phase <= 2'h0;
		endcase
	end
endmodule

// >>> result_fifo.sv
// Small result FIFO between the measure engine and the readout holding register
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_state_t;

	fifo_state_t r_reg;
	fifo_state_t r_next;
	logic push;
	logic pop;

	// Flags come from the stored count, so full and empty never lie
	assign in_ready = r_reg.count != FULL_COUNT;
	assign out_valid = r_reg.count != '0;
	assign out_data = r_reg.mem[r_reg.rd];

	// Pointer and count update; pointers wrap for any depth
	always_comb begin
		r_next = r_reg;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			r_next.mem[r_reg.wr] = in_data;
			r_next.wr = (r_reg.wr == PTR_LAST) ? '0 : r_reg.wr + 1'b1;
		end
		if (pop) begin
			r_next.rd = (r_reg.rd == PTR_LAST) ? '0 : r_reg.rd + 1'b1;
		end
		if (push && !pop) begin
			r_next.count = r_reg.count + 1'b1;
		end else if (pop && !push) begin
			r_next.count = r_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule

// >>> sequencer_pkg.sv
// Constants, state type and decode helpers for the integrate and measure sequencer
package sequencer_pkg;
	localparam int CNT_W = 11;
	localparam int DIV_W = 2;
	localparam int SEQ_W = 7;
	localparam int WORD_W = 8;
	localparam int FIFO_DEPTH = 8;

	// Measure cycle lengths and ready delay, in internal clock periods
	localparam logic [CNT_W-1:0] MEASURE_CYCLE_LOW = 11'h610;
	localparam logic [CNT_W-1:0] MEASURE_CYCLE_FAST = 11'h64c;
	localparam logic [CNT_W-1:0] SEAMLESS_READY_DELAY = 11'h566;
	localparam logic [CNT_W-1:0] CNT_STEP = 11'h001;
	// Sync, state, push and show stages that stand between select and the flag
	localparam logic [CNT_W-1:0] READY_PIPE = 11'h004;

	// Divider phase that marks an internal clock edge, and its step
	localparam logic [DIV_W-1:0] DIV_TICK = 2'h0;
	localparam logic [DIV_W-1:0] DIV_STEP = 2'h1;
	localparam logic [SEQ_W-1:0] SEQ_STEP = 7'h01;

	localparam logic SIDE_A = 1'b0;
	localparam logic SIDE_B = 1'b1;

	typedef enum logic [2:0] {
		ST1_FINISH_A,
		ST2_PREP_A,
		ST3_INT_A,
		ST4_INT_B_MEAS_A,
		ST5_INT_A_MEAS_B,
		ST6_INT_B,
		ST7_PREP_B,
		ST8_FINISH_B
	} seq_state_t;

	// Halted states keep the inputs grounded
	function automatic logic is_halted(input seq_state_t s);
		return s == ST1_FINISH_A || s == ST2_PREP_A || s == ST7_PREP_B || s == ST8_FINISH_B;
	endfunction

	function automatic logic integrates_a(input seq_state_t s);
		return s == ST3_INT_A || s == ST5_INT_A_MEAS_B;
	endfunction

	function automatic logic integrates_b(input seq_state_t s);
		return s == ST6_INT_B || s == ST4_INT_B_MEAS_A;
	endfunction
endpackage

// >>> testbench.sv
// Self-checking bench for the integrate and measure sequencer
`timescale 1ns/1ps
module testbench;
	import sequencer_pkg::*;
	logic clk_sys, rst_b, sel, quarter, fast, read_en, dsc, ready_n;
	logic int_a, int_b, gnd;
	logic [2:0] st;
	logic [WORD_W-1:0] word, got_word;
	int got_count, err_count, samples_checked;

	dual_integrator_sequencer dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.integrate_side_select(sel), .quarter_rate_divider(quarter),
		.high_speed_version(fast), .data_shift_clock(dsc),
		.result_ready_n(ready_n), .result_word(word), .seq_state(st),
		.integrate_a(int_a), .integrate_b(int_b), .inputs_grounded(gnd));
	host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .read_en(read_en),
		.result_ready_n(ready_n), .result_word(word), .data_shift_clock(dsc),
		.got_word(got_word), .got_count(got_count));

	// Free-running clock, never gated between conversions
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Bounded wait for a state code, judged after the edge settles
	task automatic wait_state(input logic [2:0] s, input int lim);
		int n;
		n = 0;
		while (st !== s && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("seq_state", st, s);
	endtask

	task automatic do_reset(input logic s, input logic q, input logic f);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		sel <= s;
		quarter <= q;
		fast <= f;
		cyc(12);
		#1;
		check("reset outs", {st, gnd, int_a, int_b, ready_n, word}, {3'h7, 4'h9, 8'h00});
		@(posedge clk_sys);
		rst_b <= 1'b1;
	endtask

	// Start level picks the side; mirror images for high and low
	task automatic run_start(input logic s);
		do_reset(s, 1'b0, 1'b0);
		wait_state(s ? 3'h2 : 3'h5, 8);
		check("start steer", {int_a, int_b, gnd}, {s, ~s, 1'b0});
	endtask

	// Toggle select, time the ready flag, then read the word
	task automatic toggle_measure(input logic v, input int m, input logic [2:0] s);
		int n;
		@(posedge clk_sys);
		sel <= v;
		n = 0;
		while (ready_n !== 1'b0 && n < 2000 * m) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("ready delay", n >= 1380 * m && n <= 1384 * m, 1'b1);
		check("cont state", {st, int_a, int_b, gnd}, {s, v, ~v, 1'b0});
		cyc(3);
		#1;
		check("word side", got_word[7], v ? SIDE_B : SIDE_A);
		cyc(1700 * m - n);
	endtask

	task automatic run_continuous(input logic q);
		int m;
		m = q ? 4 : 1;
		do_reset(1'b0, q, 1'b0);
		wait_state(3'h5, 8 * m);
		cyc(1700 * m);
		toggle_measure(1'b1, m, 3'h4);
		toggle_measure(1'b0, m, 3'h3);
		toggle_measure(1'b1, m, 3'h4);
	endtask

	// Early toggles while measuring: grounded halt, then B and A finish
	task automatic run_halted;
		int c0;
		realtime t0;
		do_reset(1'b0, 1'b0, 1'b1);
		wait_state(3'h5, 8);
		c0 = got_count;
		@(posedge clk_sys);
		sel <= 1'b1;
		t0 = $realtime;
		cyc(100);
		sel <= 1'b0;
		wait_state(3'h7, 4);
		check("halt steer", {gnd, int_a, int_b}, 3'h4);
		cyc(100);
		sel <= 1'b1;
		cyc(100);
		sel <= 1'b0;
		#1;
		check("halt stays", st, 3'h7);
		wait_state(3'h5, 4000);
		check("halt span", ($realtime - t0) / 40 >= 3224
			&& ($realtime - t0) / 40 <= 3244, 1'b1);
		check("halt words", got_count - c0, 2);
		check("last side", got_word[7], SIDE_A);
	endtask

	// Host stalls until the buffer refuses, then drains it dry
	task automatic run_fill_drain;
		int n;
		logic [WORD_W-1:0] first;
		do_reset(1'b0, 1'b0, 1'b0);
		wait_state(3'h5, 8);
		@(posedge clk_sys);
		read_en <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			sel <= ~i[0];
			cyc(1600);
		end
		first = word;
		check("stall hold", {ready_n, first[7]}, {1'b0, SIDE_B});
		read_en <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			n = 0;
			while (got_count < i + 1 && n < 2000) begin
				@(posedge clk_sys);
				#1;
				n++;
			end
			check("drain side", got_word[7], 1'(~i[0]));
			check("drain order", got_word[6:0], 7'(first[6:0] + i[6:0]));
		end
		cyc(8);
		#1;
		check("drained", ready_n, 1'b1);
	endtask

	initial begin
		rst_b = 1'b0;
		sel = 1'b0;
		quarter = 1'b0;
		fast = 1'b0;
		read_en = 1'b1;
		err_count = 0;
		samples_checked = 0;
		run_start(1'b1);
		run_start(1'b0);
		run_continuous(1'b0);
		run_continuous(1'b1);
		run_halted();
		run_fill_drain();
		tally_and_finish();
	end

	// Hang guard, nearly twice the expected run
	initial begin
		#4000000;
		err_count++;
		tally_and_finish();
	end
endmodule
